// >>> hdl/led_fault_pkg.sv
// constants shared by the led string fault supervisor files
package led_fault_pkg;

  // clock and timing
  localparam int CLK_PERIOD_NS         = 10;
  localparam int DISABLE_OSC_PERIODS   = 32768;
  localparam int BLANK_TIME_NS         = 20480;
  localparam int BLANK_CYCLES          = (BLANK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // register bus
  localparam int          AXI_ADDR_W   = 8;
  localparam logic [7:0]  OFF_CTRL     = 8'h00;
  localparam logic [7:0]  OFF_STATUS   = 8'h04;
  localparam logic [7:0]  OFF_BLANK    = 8'h08;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  // ctrl fields
  localparam int          CTRL_RUN_BIT = 0;
  localparam logic        CTRL_RUN_RST = 1'b1;

  // blank fields
  localparam int          BLANK_W      = 16;
  localparam logic [15:0] BLANK_RST    = 16'(BLANK_CYCLES);

  // status fields
  localparam int ST_SHORT_LED  = 0;
  localparam int ST_STR_FAULT  = 1;
  localparam int ST_OPEN_LED   = 2;
  localparam int ST_LATCHED    = 3;
  localparam int ST_BLANKING   = 4;
  localparam int ST_SLEEPING   = 5;
  localparam int ST_OVERRIDE   = 6;
  localparam int ST_GATE       = 7;

  // positions in the synchronised input bundle
  localparam int IN_OPEN_LED     = 0;
  localparam int IN_REF_SHORT    = 1;
  localparam int IN_NONREF_SHORT = 2;
  localparam int IN_STRING_SHORT = 3;
  localparam int IN_OUTPUT_SHORT = 4;
  localparam int IN_ENABLE_DIM   = 5;
  localparam int IN_PROT_PIN     = 6;
  localparam int IN_W            = 7;

endpackage

// >>> hdl/fault_inputs_if.sv
// bundle of synchronised comparator and pin levels
`timescale 1ns/10ps
`default_nettype none

interface fault_inputs_if;
  logic [led_fault_pkg::IN_W-1:0] level;

  modport producer (output level);
  modport consumer (input level);
endinterface

`default_nettype wire

// >>> hdl/input_sync.sv
// two-flop synchroniser for the asynchronous comparator and pin inputs
`timescale 1ns/10ps
`default_nettype none

module input_sync #(
  parameter int WIDTH = led_fault_pkg::IN_W
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [WIDTH-1:0] raw,
  fault_inputs_if.producer      bus
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } sync_state_t;

  sync_state_t st_reg;
  sync_state_t st_next;

  if (WIDTH != led_fault_pkg::IN_W)
  begin : g_width_check
    $error("input_sync WIDTH must match the input bundle");
  end

  // stage1 feeds stage2 only; nothing else looks at it
  always_comb
  begin
    st_next        = st_reg;
    st_next.stage1 = raw;
    st_next.stage2 = st_reg.stage1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign bus.level = st_reg.stage2;

endmodule // input_sync

`default_nettype wire

// >>> hdl/led_fault_supervisor.sv
// fault supervisor for a boost led driver with an axi4-lite register slave
//
// Summary of operation
// - open-led fault acts at once, never blanked
// - shorted led when either short comparator fires
// - shorted led releases warning flag, switching continues
// - shorted led not latched, flag follows condition
// - string below short threshold means shorted string
// - output short handled exactly like shorted string
// - string fault forces gate low, releases protection flag
// - string fault latched until long enable low
// - outside pulling protection flag low resumes switching
// - disable time is fixed count of clock periods
// - flags pull down when healthy, released on fault
// - short detection waits out blanking after start
`timescale 1ns/10ps
`default_nettype none

module led_fault_supervisor #(
  parameter int DISABLE_CYCLES = led_fault_pkg::DISABLE_OSC_PERIODS
) (
  input  wire logic                                aclk,
  input  wire logic                                aresetn,
  // axi4-lite slave
  input  wire logic [led_fault_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                                s_axi_awvalid,
  output logic                                     s_axi_awready,
  input  wire logic [31:0]                         s_axi_wdata,
  input  wire logic [3:0]                          s_axi_wstrb,
  input  wire logic                                s_axi_wvalid,
  output logic                                     s_axi_wready,
  output logic [1:0]                               s_axi_bresp,
  output logic                                     s_axi_bvalid,
  input  wire logic                                s_axi_bready,
  input  wire logic [led_fault_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                                s_axi_arvalid,
  output logic                                     s_axi_arready,
  output logic [31:0]                              s_axi_rdata,
  output logic [1:0]                               s_axi_rresp,
  output logic                                     s_axi_rvalid,
  input  wire logic                                s_axi_rready,
  // analog comparator results, asynchronous
  input  wire logic                                open_led_cmp,
  input  wire logic                                ref_short_cmp,
  input  wire logic                                nonref_short_cmp,
  input  wire logic                                string_short_cmp,
  input  wire logic                                output_short_cmp,
  // enable / dimming pin, asynchronous
  input  wire logic                                enable_dim,
  // switching regulator request, same clock
  input  wire logic                                gate_request,
  output logic                                     gate_drive_out,
  // open-drain flags: level, drive enable, pin readback
  input  wire logic                                protection_fault_flag_i,
  output logic                                     protection_fault_flag_o,
  output logic                                     protection_fault_flag_oe,
  output logic                                     warning_fault_flag_o,
  output logic                                     warning_fault_flag_oe
);

  localparam int AW = led_fault_pkg::AXI_ADDR_W;
  localparam int BW = led_fault_pkg::BLANK_W;

  if (DISABLE_CYCLES < 2 || DISABLE_CYCLES > 65536)
  begin : g_dis_check
    $error("DISABLE_CYCLES must lie in 2..65536");
  end

  localparam logic [15:0] DIS_LAST = 16'(DISABLE_CYCLES - 1);

  typedef struct packed {
    // write channel
    logic          awready;
    logic          wready;
    logic          aw_held;
    logic [AW-1:0] aw_addr;
    logic          w_held;
    logic [31:0]   wdata;
    logic [3:0]    wstrb;
    logic          bvalid;
    logic [1:0]    bresp;
    // read channel
    logic          arready;
    logic          rvalid;
    logic [31:0]   rdata;
    logic [1:0]    rresp;
    // software registers
    logic          ctrl_run;
    logic [BW-1:0] blank_len;
    // supervisor
    logic          sleeping;
    logic [15:0]   dis_cnt;
    logic          blanking;
    logic [BW-1:0] blank_cnt;
    logic          short_latch;
    logic          override;
    logic [1:0]    oe_hist;
    logic          gate;
    logic          prot_oe;
    logic          warn_oe;
  } sup_state_t;

  sup_state_t st_reg;
  sup_state_t st_next;

  fault_inputs_if sync_bus ();

  input_sync #(
    .WIDTH (led_fault_pkg::IN_W)
  ) u_input_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .raw     ({protection_fault_flag_i, enable_dim, output_short_cmp, string_short_cmp,
               nonref_short_cmp, ref_short_cmp, open_led_cmp}),
    .bus     (sync_bus.producer)
  );

  logic in_open;
  logic in_short_led;
  logic in_str_fault;
  logic in_enable;
  logic in_prot_pin;

  assign in_open      = sync_bus.level[led_fault_pkg::IN_OPEN_LED];
  assign in_short_led = sync_bus.level[led_fault_pkg::IN_REF_SHORT]
                      | sync_bus.level[led_fault_pkg::IN_NONREF_SHORT];
  assign in_str_fault = sync_bus.level[led_fault_pkg::IN_STRING_SHORT]
                      | sync_bus.level[led_fault_pkg::IN_OUTPUT_SHORT];
  assign in_enable    = sync_bus.level[led_fault_pkg::IN_ENABLE_DIM];
  assign in_prot_pin  = sync_bus.level[led_fault_pkg::IN_PROT_PIN];

  // merge byte lanes of a write into an old word
  function automatic logic [31:0] merge_lanes(input logic [31:0] old_word,
                                              input logic [31:0] new_word,
                                              input logic [3:0]  strb);
    logic [31:0] result;
    result = old_word;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
        result[8*i +: 8] = new_word[8*i +: 8];
    end
    return result;
  endfunction

  function automatic logic is_mapped(input logic [AW-1:0] addr);
    return addr == AW'(led_fault_pkg::OFF_CTRL) || addr == AW'(led_fault_pkg::OFF_STATUS)
        || addr == AW'(led_fault_pkg::OFF_BLANK);
  endfunction

  function automatic logic [31:0] status_word(input sup_state_t s,
                                              input logic sl, input logic sf, input logic op);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[led_fault_pkg::ST_SHORT_LED] = sl;
    w[led_fault_pkg::ST_STR_FAULT] = sf;
    w[led_fault_pkg::ST_OPEN_LED]  = op;
    w[led_fault_pkg::ST_LATCHED]   = s.short_latch;
    w[led_fault_pkg::ST_BLANKING]  = s.blanking;
    w[led_fault_pkg::ST_SLEEPING]  = s.sleeping;
    w[led_fault_pkg::ST_OVERRIDE]  = s.override;
    w[led_fault_pkg::ST_GATE]      = s.gate;
    return w;
  endfunction

  always_comb
  begin
    logic [31:0] ctrl_word;
    logic [31:0] merged;
    logic        detect_on;
    logic        str_now;
    logic        warn_fault;
    ctrl_word = 32'h0000_0000;
    merged    = 32'h0000_0000;
    detect_on = 1'b0;
    str_now   = 1'b0;
    warn_fault = 1'b0;
    st_next   = st_reg;

    ctrl_word[led_fault_pkg::CTRL_RUN_BIT] = st_reg.ctrl_run;

    // write side: address and data accepted in either order
    if (s_axi_awvalid && st_reg.awready)
    begin
      st_next.aw_held = 1'b1;
      st_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_reg.wready)
    begin
      st_next.w_held = 1'b1;
      st_next.wdata  = s_axi_wdata;
      st_next.wstrb  = s_axi_wstrb;
    end
    if (st_reg.bvalid && s_axi_bready)
      st_next.bvalid = 1'b0;
    if (st_reg.aw_held && st_reg.w_held && !st_reg.bvalid)
    begin
      st_next.aw_held = 1'b0;
      st_next.w_held  = 1'b0;
      st_next.bvalid  = 1'b1;
      st_next.bresp   = is_mapped(st_reg.aw_addr) ? led_fault_pkg::RESP_OKAY
                                                  : led_fault_pkg::RESP_SLVERR;
      if (st_reg.aw_addr == AW'(led_fault_pkg::OFF_CTRL))
      begin
        merged           = merge_lanes(ctrl_word, st_reg.wdata, st_reg.wstrb);
        st_next.ctrl_run = merged[led_fault_pkg::CTRL_RUN_BIT];
      end
      else if (st_reg.aw_addr == AW'(led_fault_pkg::OFF_BLANK))
      begin
        merged            = merge_lanes({16'h0000, st_reg.blank_len}, st_reg.wdata, st_reg.wstrb);
        st_next.blank_len = merged[BW-1:0];
      end
    end
    // no new address or data while a response waits
    st_next.awready = !st_next.aw_held && !st_next.bvalid;
    st_next.wready  = !st_next.w_held && !st_next.bvalid;

    // read side: one cycle from address to data
    if (st_reg.rvalid && s_axi_rready)
      st_next.rvalid = 1'b0;
    if (s_axi_arvalid && st_reg.arready)
    begin
      st_next.rvalid = 1'b1;
      st_next.rresp  = is_mapped(s_axi_araddr) ? led_fault_pkg::RESP_OKAY
                                               : led_fault_pkg::RESP_SLVERR;
      if (s_axi_araddr == AW'(led_fault_pkg::OFF_CTRL))
        st_next.rdata = ctrl_word;
      else if (s_axi_araddr == AW'(led_fault_pkg::OFF_STATUS))
        st_next.rdata = status_word(st_reg, in_short_led, in_str_fault, in_open);
      else if (s_axi_araddr == AW'(led_fault_pkg::OFF_BLANK))
        st_next.rdata = {16'h0000, st_reg.blank_len};
      else
        st_next.rdata = 32'h0000_0000;
    end
    st_next.arready = !st_next.rvalid;

    // enable low long enough puts the supervisor to sleep
    if (!in_enable)
    begin
      if (st_reg.dis_cnt == DIS_LAST)
        st_next.sleeping = 1'b1;
      else
        st_next.dis_cnt = st_reg.dis_cnt + 16'h0001;
    end
    else
    begin
      st_next.dis_cnt  = 16'h0000;
      st_next.sleeping = 1'b0;
    end

    // blanking restarts while asleep so wake-up sees a fresh interval
    if (st_reg.sleeping)
    begin
      st_next.blanking  = 1'b1;
      st_next.blank_cnt = '0;
    end
    else if (st_reg.blanking)
    begin
      st_next.blank_cnt = BW'(st_reg.blank_cnt + 1'b1);
      if (BW'(st_reg.blank_cnt + 1'b1) >= st_reg.blank_len)
        st_next.blanking = 1'b0;
    end

    detect_on = !st_reg.blanking && !st_reg.sleeping;
    str_now   = detect_on && in_str_fault;

    // sleep clears the latch; a short seen while asleep is not kept
    if (st_reg.sleeping)
      st_next.short_latch = 1'b0;
    else if (str_now)
      st_next.short_latch = 1'b1;

    // pin read low while we are released means the outside pulls it down;
    // the readback lags our release through the synchroniser, so wait it out
    st_next.oe_hist  = {st_reg.oe_hist[0], st_reg.prot_oe};
    st_next.override = st_reg.short_latch && !st_reg.prot_oe && (st_reg.oe_hist == 2'b00)
                    && !in_prot_pin;

    // open-led bypasses blanking to keep high voltage off the switch
    warn_fault = in_open || (detect_on && in_short_led);

    st_next.gate = gate_request && st_reg.ctrl_run && in_enable && !st_reg.sleeping
                && !in_open
                && (!(st_reg.short_latch || str_now) || st_reg.override);

    // flags: drive low when healthy, release on fault or in sleep
    st_next.prot_oe = !st_reg.sleeping && !st_reg.short_latch && !str_now;
    st_next.warn_oe = !st_reg.sleeping && !warn_fault;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_reg           <= '0;
      st_reg.awready   <= 1'b1;
      st_reg.wready    <= 1'b1;
      st_reg.arready   <= 1'b1;
      st_reg.ctrl_run  <= led_fault_pkg::CTRL_RUN_RST;
      st_reg.blank_len <= led_fault_pkg::BLANK_RST;
      st_reg.blanking  <= 1'b1;
    end
    else
      st_reg <= st_next;
  end

  assign s_axi_awready = st_reg.awready;
  assign s_axi_wready  = st_reg.wready;
  assign s_axi_bvalid  = st_reg.bvalid;
  assign s_axi_bresp   = st_reg.bresp;
  assign s_axi_arready = st_reg.arready;
  assign s_axi_rvalid  = st_reg.rvalid;
  assign s_axi_rdata   = st_reg.rdata;
  assign s_axi_rresp   = st_reg.rresp;

  assign gate_drive_out           = st_reg.gate;
  // open-drain: the driven level is always low, only the enable moves
  assign protection_fault_flag_o  = 1'b0;
  assign protection_fault_flag_oe = st_reg.prot_oe;
  assign warning_fault_flag_o     = 1'b0;
  assign warning_fault_flag_oe    = st_reg.warn_oe;

endmodule // led_fault_supervisor

`default_nettype wire

// >>> verif/led_fault_props.sv
// assertion checker for the led string fault supervisor ports
`timescale 1ns/10ps
`default_nettype none

module led_fault_props #(
  parameter int DISABLE_CYCLES = led_fault_pkg::DISABLE_OSC_PERIODS
) (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        open_led_cmp,
  input wire logic        ref_short_cmp,
  input wire logic        nonref_short_cmp,
  input wire logic        enable_dim,
  input wire logic        gate_request,
  input wire logic        gate_drive_out,
  input wire logic        protection_fault_flag_i,
  input wire logic        protection_fault_flag_o,
  input wire logic        protection_fault_flag_oe,
  input wire logic        warning_fault_flag_o,
  input wire logic        warning_fault_flag_oe
);
  // the disable count is far past any repetition, so count low cycles here
  int unsigned low_cnt;

  always_ff @(posedge aclk)
  begin
    if (!aresetn || enable_dim)
      low_cnt <= 0;
    else if (low_cnt < DISABLE_CYCLES + 8)
      low_cnt <= low_cnt + 1;
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_open_gate;
    open_led_cmp [*4] |=> !gate_drive_out;
  endproperty
  a_open_gate: assert property (p_open_gate)
    else $error("gate on while open led present");

  property p_warn_clear;
    (!ref_short_cmp && !nonref_short_cmp && !open_led_cmp && enable_dim) [*5]
      |=> warning_fault_flag_oe;
  endproperty
  a_warn_clear: assert property (p_warn_clear)
    else $error("warning flag not pulled low when healthy");

  property p_drain;
    !protection_fault_flag_o && !warning_fault_flag_o;
  endproperty
  a_drain: assert property (p_drain)
    else $error("flag output drives high");

  property p_gate_req;
    gate_drive_out |-> $past(gate_request);
  endproperty
  a_gate_req: assert property (p_gate_req)
    else $error("gate on without request");

  property p_prot_gate;
    $fell(protection_fault_flag_oe) && enable_dim |-> !gate_drive_out;
  endproperty
  a_prot_gate: assert property (p_prot_gate)
    else $error("gate on when string fault latched");

  property p_fault_hold;
    $fell(protection_fault_flag_oe) && enable_dim && protection_fault_flag_i
      |=> !gate_drive_out [*3];
  endproperty
  a_fault_hold: assert property (p_fault_hold)
    else $error("gate pulses after string fault");

  property p_latch_hold;
    ($fell(protection_fault_flag_oe) && enable_dim) ##1 enable_dim [*7]
      |-> !protection_fault_flag_oe;
  endproperty
  a_latch_hold: assert property (p_latch_hold)
    else $error("string fault dropped while enabled");

  property p_override;
    (!protection_fault_flag_oe && !protection_fault_flag_i && enable_dim && !open_led_cmp) [*6]
      |=> gate_drive_out == $past(gate_request);
  endproperty
  a_override: assert property (p_override)
    else $error("override does not resume switching");

  property p_sleep;
    low_cnt >= DISABLE_CYCLES + 6 |-> !protection_fault_flag_oe && !warning_fault_flag_oe;
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("flags not released after disable time");

  property p_r_ans;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_r_ans: assert property (p_r_ans)
    else $error("read not answered next cycle");

  property p_b_ans;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_b_ans: assert property (p_b_ans)
    else $error("write channel ready during response");

  c_latch: cover property ($fell(protection_fault_flag_oe) && enable_dim);
  c_override: cover property (!protection_fault_flag_oe && !protection_fault_flag_i && gate_drive_out);
  c_sleep: cover property (low_cnt == DISABLE_CYCLES + 6);
endmodule // led_fault_props

bind led_fault_supervisor led_fault_props #(.DISABLE_CYCLES(DISABLE_CYCLES)) i_led_fault_props (.*);

`default_nettype wire

// >>> verif/fault_monitor_model.sv
// external fault monitor: pull-ups on both flags and an override switch
`timescale 1ns/10ps
`default_nettype none

module fault_monitor_model (
  input  wire logic prot_o,
  input  wire logic prot_oe,
  input  wire logic warn_o,
  input  wire logic warn_oe,
  input  wire logic pull_prot,
  output logic      prot_pin,
  output logic      warn_pin
);
  // pull-up wins whenever nobody sinks the line
  assign prot_pin = !((prot_oe && !prot_o) || pull_prot);
  assign warn_pin = !(warn_oe && !warn_o);
endmodule // fault_monitor_model

`default_nettype wire

// >>> verif/led_fault_supervisor_tb.sv
// self-checking testbench for the led string fault supervisor
`timescale 1ns/10ps
`default_nettype none

module led_fault_supervisor_tb;
  localparam int DIS = 16;
  typedef struct {logic [31:0] data; logic [31:0] mask; logic [1:0] resp;} exp_t;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_rready, open_led_cmp, ref_short_cmp, nonref_short_cmp, string_short_cmp;
  logic        output_short_cmp, enable_dim, gate_request, pull_prot, req_seen, warn_pin;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        gate_drive_out, protection_fault_flag_i, protection_fault_flag_o;
  logic        protection_fault_flag_oe, warning_fault_flag_o, warning_fault_flag_oe;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  exp_t        exp_q[$];
  int          num_errors, checks, i;
  int          seed = 2;

  led_fault_supervisor #(.DISABLE_CYCLES(DIS)) i_led_fault_supervisor (.*);

  fault_monitor_model i_fault_monitor_model (
    .prot_o(protection_fault_flag_o), .prot_oe(protection_fault_flag_oe),
    .warn_o(warning_fault_flag_o), .warn_oe(warning_fault_flag_oe),
    .pull_prot(pull_prot), .prot_pin(protection_fault_flag_i), .warn_pin(warn_pin));

  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic cmp_resp(input logic [31:0] d, input logic [1:0] r);
    exp_t e;
    e = '{32'h0, 32'h0, 2'h3};
    if (exp_q.size() > 0)
      e = exp_q.pop_front();
    check("rdata", d & e.mask, e.data);
    check("resp", 32'(r), 32'(e.resp));
  endtask

  // answers are judged here, in order of issue
  always @(posedge aclk)
  begin
    if (s_axi_rvalid && s_axi_rready)
      cmp_resp(s_axi_rdata, s_axi_rresp);
    if (s_axi_bvalid && s_axi_bready)
      cmp_resp(32'h0, s_axi_bresp);
  end

  always @(posedge aclk)
  begin
    gate_request <= 1'($random(seed));
    req_seen <= gate_request;
  end

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    exp_q.push_back('{32'h0, 32'h0, r});
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
        break;
    end
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
                        input logic [1:0] r);
    exp_q.push_back('{d & m, m, r});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
        break;
    end
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask

  // gate either follows the request or stays low
  task automatic pins(input logic follow, input logic po, input logic wo);
    repeat (6)
    begin
      @(negedge aclk);
      check("gate", 32'(gate_drive_out), 32'(follow ? req_seen : 1'b0));
      check("prot_oe", 32'(protection_fault_flag_oe), 32'(po));
      check("warn_oe", 32'(warning_fault_flag_oe), 32'(wo));
      check("warn_pin", 32'(warn_pin), 32'(!wo));
    end
    @(posedge aclk);
  endtask

  initial
  begin
    repeat (10000) @(posedge aclk);
    num_errors++;
    end_of_test();
  end

  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    {open_led_cmp, ref_short_cmp, nonref_short_cmp, string_short_cmp} = 4'h0;
    {output_short_cmp, pull_prot} = 2'h0;
    enable_dim = 1'b1;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'h3;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axi_rd(led_fault_pkg::OFF_CTRL, 32'h1, 32'h1, led_fault_pkg::RESP_OKAY);
    axi_rd(led_fault_pkg::OFF_BLANK, 32'h800, 32'hFFFF, led_fault_pkg::RESP_OKAY);
    axi_rd(led_fault_pkg::OFF_STATUS, 32'h10, 32'h18, led_fault_pkg::RESP_OKAY);
    ref_short_cmp <= 1'b1;
    string_short_cmp <= 1'b1;
    repeat (4) @(posedge aclk);
    pins(1'b1, 1'b1, 1'b1);
    open_led_cmp <= 1'b1;
    repeat (4) @(posedge aclk);
    pins(1'b0, 1'b1, 1'b0);
    {open_led_cmp, ref_short_cmp, string_short_cmp} <= 3'h0;
    repeat (4) @(posedge aclk);
    axi_rd(led_fault_pkg::OFF_STATUS, 32'h10, 32'h1F, led_fault_pkg::RESP_OKAY);
    axi_wr(led_fault_pkg::OFF_BLANK, 32'h28, led_fault_pkg::RESP_OKAY);
    axi_wr(8'h0C, 32'hFFFFFFFF, led_fault_pkg::RESP_SLVERR);
    axi_wr(led_fault_pkg::OFF_STATUS, 32'hFF, led_fault_pkg::RESP_OKAY);
    axi_rd(8'h0C, 32'h0, 32'hFFFFFFFF, led_fault_pkg::RESP_SLVERR);
    axi_rd(led_fault_pkg::OFF_BLANK, 32'h28, 32'hFFFF, led_fault_pkg::RESP_OKAY);
    axi_wr(led_fault_pkg::OFF_CTRL, 32'h0, led_fault_pkg::RESP_OKAY);
    pins(1'b0, 1'b1, 1'b1);
    axi_rd(led_fault_pkg::OFF_CTRL, 32'h0, 32'h1, led_fault_pkg::RESP_OKAY);
    axi_wr(led_fault_pkg::OFF_CTRL, 32'h1, led_fault_pkg::RESP_OKAY);
    repeat (2100) @(posedge aclk);
    pins(1'b1, 1'b1, 1'b1);
    for (i = 0; i < 2; i++)
    begin
      ref_short_cmp <= (i == 0);
      nonref_short_cmp <= (i == 1);
      repeat (4) @(posedge aclk);
      pins(1'b1, 1'b1, 1'b0);
      axi_rd(led_fault_pkg::OFF_STATUS, 32'h1, 32'h1B, led_fault_pkg::RESP_OKAY);
      ref_short_cmp <= 1'b0;
      nonref_short_cmp <= 1'b0;
      repeat (4) @(posedge aclk);
      pins(1'b1, 1'b1, 1'b1);
    end
    for (i = 0; i < 2; i++)
    begin
      string_short_cmp <= (i == 0);
      output_short_cmp <= (i == 1);
      repeat (3) @(posedge aclk);
      string_short_cmp <= 1'b0;
      output_short_cmp <= 1'b0;
      repeat (4) @(posedge aclk);
      pins(1'b0, 1'b0, 1'b1);
      pull_prot <= 1'b1;
      repeat (6) @(posedge aclk);
      pins(1'b1, 1'b0, 1'b1);
      axi_rd(led_fault_pkg::OFF_STATUS, 32'h48, 32'h4A, led_fault_pkg::RESP_OKAY);
      pull_prot <= 1'b0;
      enable_dim <= 1'b0;
      repeat (DIS - 4) @(posedge aclk);
      enable_dim <= 1'b1;
      repeat (6) @(posedge aclk);
      axi_rd(led_fault_pkg::OFF_STATUS, 32'h08, 32'h28, led_fault_pkg::RESP_OKAY);
      enable_dim <= 1'b0;
      repeat (DIS + 6) @(posedge aclk);
      pins(1'b0, 1'b0, 1'b0);
      axi_rd(led_fault_pkg::OFF_STATUS, 32'h20, 32'h28, led_fault_pkg::RESP_OKAY);
      enable_dim <= 1'b1;
      repeat (6) @(posedge aclk);
      axi_rd(led_fault_pkg::OFF_STATUS, 32'h10, 32'h18, led_fault_pkg::RESP_OKAY);
      repeat (50) @(posedge aclk);
      pins(1'b1, 1'b1, 1'b1);
    end
    end_of_test();
  end
endmodule // led_fault_supervisor_tb

`default_nettype wire
